/* File: tb/pgrr_host.sv */
// Purpose: host-side model driving the sleep lines
// Assumes: lines move one edge after a request
// Notes: s4/s3 only rise while resume good is high, as a real host would
`timescale 1ns/1ns
module pgrr_host (
  input wire logic clk_i,
  input wire logic rrg_i,
  input wire logic [2:0] req_i,
  output logic s4_n_o = 1'b0,
  output logic s3_n_o = 1'b0,
  output logic s0ix_n_o = 1'b1
);
  always @(posedge clk_i)
  begin
    s4_n_o <= req_i[2] & rrg_i;
    s3_n_o <= req_i[1] & rrg_i;
    s0ix_n_o <= req_i[0];
  end
endmodule

/* File: tb/pgrr_props.sv */
// Purpose: port-level checks of the power-good and register-reset block
// Assumes: CE_I high except in one freeze test that writes no control bit
// Notes: pin paths settle 3 edges after the pin moves
`timescale 1ns/1ns
module pgrr_props
  import pgrr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic SUPPLY_OK_I,
  input wire logic SUPPLY_LOW_I,
  input wire logic CHIP_EN_I,
  input wire logic SLEEP_S4_N_I,
  input wire logic SLEEP_S3_N_I,
  input wire logic [RAIL_N-1:0] RAIL_FAULT_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RESUME_RESET_GOOD_N_O,
  input wire logic PLATFORM_POWER_OK_O,
  input wire logic [RAIL_N-1:0] PWM_FORCE_O,
  input wire logic [MV_W-1:0] CORE_MV_O,
  input wire logic REG_RESET_O,
  input wire logic SHUTDOWN_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  rrg_qual_a: assert property (RESUME_RESET_GOOD_N_O |->
    $past(SUPPLY_OK_I, 3) && $past(CHIP_EN_I, 3)) else $error("resume good unqualified");
  pwrok_qual_a: assert property (PLATFORM_POWER_OK_O |->
    $past(SLEEP_S3_N_I, 3) && $past(SLEEP_S4_N_I, 3) && $past(SUPPLY_OK_I, 3))
    else $error("power ok unqualified");
  supply_drop_a: assert property (!SUPPLY_OK_I |->
    ##3 !RESUME_RESET_GOOD_N_O && !PLATFORM_POWER_OK_O) else $error("slow supply drop");
  fault_drop_a: assert property (|RAIL_FAULT_I |->
    ##3 !RESUME_RESET_GOOD_N_O && !PLATFORM_POWER_OK_O) else $error("slow fault drop");
  // reset stays level while supply is low, yet a window of two edges is allowed
  supply_undervoltage_lockout_reset_a: assert property (SUPPLY_LOW_I |-> ##[3:4] REG_RESET_O)
    else $error("no reset on low supply");
  soft_shutdown_bit_write_a: assert property (WR_I && ADDR_I == A_CTRL && WDATA_I[B_SOFT_SHUTDOWN_BIT] |=>
    REG_RESET_O && SHUTDOWN_O) else $error("soft shutdown missed");
  core_auto_a: assert property (PWM_FORCE_O[1:0] == 2'h0)
    else $error("core or graphics forced");
  vcode_map_a: assert property (CORE_MV_O == 11'h000 || (CORE_MV_O >= 11'h1f4 &&
    CORE_MV_O <= 11'h686 && CORE_MV_O % 11'h00a == 11'h000)) else $error("bad voltage");
endmodule

/* File: tb/tb_pgrr_top.sv */
// Purpose: directed bench for the power-good and register-reset block
// Assumes: CE_I high but for one freeze test; pins and port driven on rising edges
// Notes: pin effects settle in 3 edges, so short fixed waits suffice
`timescale 1ns/1ns
module tb_pgrr_top;
  import pgrr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sup_ok = 1'b1;
  logic sup_low = 1'b0;
  logic en = 1'b1;
  // low from power-up: ignored until resume good first rises
  logic trip_n = 1'b0;
  logic crit = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic rr_seen = 1'b0;
  logic rg_seen = 1'b0;
  logic sd_seen = 1'b0;
  logic ce = 1'b1;
  logic [2:0] slp_req = 3'h7;
  logic [5:0] good = 6'h3f;
  logic [5:0] fault = 6'h00;
  logic [5:0] dvs = 6'h00;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, d;
  logic rrg, pok, rr, sd, irq, s4_n, s3_n, s0_n;
  logic [5:0] pwm;
  logic [10:0] core_mv, gfx_mv;
  int errors = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (rr) rr_seen <= 1'b1;
  always @(posedge clk) if (rrg) rg_seen <= 1'b1;
  always @(posedge clk) if (sd) sd_seen <= 1'b1;
  pgrr_top u_dut (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .SUPPLY_OK_I(sup_ok),
    .SUPPLY_LOW_I(sup_low), .CHIP_EN_I(en), .THERMAL_TRIP_N_I(trip_n), .SLEEP_S4_N_I(s4_n),
    .SLEEP_S3_N_I(s3_n), .SLEEP_S0IX_N_I(s0_n), .CRIT_TEMP_I(crit), .RAIL_GOOD_I(good),
    .RAIL_FAULT_I(fault), .DVS_ACTIVE_I(dvs), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
    .RD_I(rd_s), .RDATA_O(rdata), .RESUME_RESET_GOOD_N_O(rrg), .PLATFORM_POWER_OK_O(pok),
    .PWM_FORCE_O(pwm), .CORE_MV_O(core_mv), .GFX_MV_O(gfx_mv), .REG_RESET_O(rr),
    .SHUTDOWN_O(sd), .IRQ_O(irq));
  pgrr_host u_host (.clk_i(clk), .rrg_i(rrg), .req_i(slp_req), .s4_n_o(s4_n),
    .s3_n_o(s3_n), .s0ix_n_o(s0_n));
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [10:0] mv(input logic [6:0] c);
    return c == 7'h00 ? 11'h000 : 11'h1ea + 11'h00a * (c > 7'h76 ? 7'h76 : c);
  endfunction
  task end_of_test;
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task t_power;
    chk(rg_seen, 1'b1);
    chk({rrg, pok}, 2'h0);
    trip_n <= 1'b1;
    cyc(10);
    chk({rrg, pok}, 2'h3);
    good[2] <= 1'b0;
    cyc(4);
    chk({rrg, pok}, 2'h2);
    good <= 6'h3e;
    cyc(4);
    chk({rrg, pok}, 2'h2);
    good <= 6'h2f;
    dvs <= 6'h10;
    cyc(4);
    chk(rrg, 1'b1);
    dvs <= 6'h00;
    cyc(4);
    chk({rrg, pok}, 2'h0);
    good <= 6'h3f;
    sup_ok <= 1'b0;
    cyc(4);
    chk({rrg, pok}, 2'h0);
    sup_ok <= 1'b1;
    cyc(12);
    chk({rrg, pok}, 2'h3);
  endtask
  // one register-reset cause per call; mode register is the witness
  task t_rst(input int k);
    wr(A_MODE, 32'h5);
    #1 rr_seen = 1'b0;
    sd_seen = 1'b0;
    case (k)
      0: sup_low <= 1'b1;
      1: en <= 1'b0;
      2: trip_n <= 1'b0;
      3: fault <= 6'h20;
      4: crit <= 1'b1;
      default: wr(A_CTRL, 32'h1);
    endcase
    cyc(6);
    {sup_low, en, trip_n, fault, crit} <= {1'b0, 1'b1, 1'b1, 6'h00, 1'b0};
    cyc(14);
    chk(rr_seen, 1'b1);
    chk(sd_seen, k >= 4);
    rd(A_MODE);
    chk(d, 32'h0);
  endtask
  task t_mask;
    wr(A_FMASK, 32'h20);
    wr(A_MODE, 32'h5);
    fault <= 6'h20;
    cyc(8);
    fault <= 6'h00;
    cyc(4);
    rd(A_MODE);
    chk(d, 32'h5);
  endtask
  // aux always-on: an enable fall must leave registers alone
  task t_aux;
    wr(A_CTRL, 32'h2);
    wr(A_MODE, 32'h6);
    #1 rr_seen = 1'b0;
    en <= 1'b0;
    cyc(6);
    en <= 1'b1;
    cyc(14);
    chk(rr_seen, 1'b0);
    rd(A_MODE);
    chk(d, 32'h6);
  endtask
  // clock enable low: a write must not land
  task t_ce;
    wr(A_MODE, 32'h3);
    ce <= 1'b0;
    wr(A_MODE, 32'hc);
    ce <= 1'b1;
    rd(A_MODE);
    chk(d, 32'h3);
    chk(pwm, 6'h0c);
  endtask
  task t_mode;
    for (int i = 0; i < 4; i++)
    begin
      wr(A_MODE, 32'h1 << i);
      cyc(2);
      chk(pwm, 6'h04 << i);
    end
  endtask
  task t_vc;
    logic [6:0] c [7] = '{7'h00, 7'h01, 7'h02, 7'h38, 7'h75, 7'h76, 7'h7f};
    for (int i = 0; i < 7; i++)
    begin
      wr(A_CORE_VC, {25'h0, c[i]});
      wr(A_GFX_VC, {25'h0, c[i]});
      cyc(2);
      chk({core_mv, gfx_mv}, {mv(c[i]), mv(c[i])});
    end
    for (int i = 0; i < 2; i++)
    begin
      wr(A_CORE_VC, 32'h1);
      wr(A_GFX_VC, 32'h1);
      slp_req <= i ? 3'h5 : 3'h6;
      cyc(8);
      chk({core_mv, gfx_mv}, {11'h41a, 11'h3e8});
      slp_req <= 3'h7;
      cyc(12);
    end
  endtask
  task t_irq;
    wr(A_IRQ_ST, 32'h1f);
    wr(A_CTRL, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    wr(A_IRQ_MSK, 32'h1 << E_REG_RST);
    cyc(2);
    chk(irq, 1'b1);
    wr(A_IRQ_ST, 32'h1 << E_REG_RST);
    cyc(2);
    chk(irq, 1'b0);
    rd(8'h40);
    chk(d, 32'h0);
  endtask
  initial
  begin
    cyc(4);
    rst <= 1'b0;
    cyc(14);
    t_power;
    for (int k = 0; k < 6; k++)
      t_rst(k);
    t_mask;
    t_aux;
    t_mode;
    t_ce;
    t_vc;
    t_irq;
    end_of_test;
  end
  // hang guard, well beyond the directed run
  initial
  begin
    #400000;
    errors++;
    end_of_test;
  end
endmodule
bind pgrr_top pgrr_props u_props (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .WR_I(WR_I),
  .SUPPLY_OK_I(SUPPLY_OK_I), .SUPPLY_LOW_I(SUPPLY_LOW_I), .CHIP_EN_I(CHIP_EN_I),
  .SLEEP_S4_N_I(SLEEP_S4_N_I), .SLEEP_S3_N_I(SLEEP_S3_N_I), .RAIL_FAULT_I(RAIL_FAULT_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RESUME_RESET_GOOD_N_O(RESUME_RESET_GOOD_N_O),
  .PLATFORM_POWER_OK_O(PLATFORM_POWER_OK_O), .PWM_FORCE_O(PWM_FORCE_O),
  .CORE_MV_O(CORE_MV_O), .REG_RESET_O(REG_RESET_O), .SHUTDOWN_O(SHUTDOWN_O));

/* File: verilog/pgrr_pkg.sv */
// Purpose: shared constants for the power-good and register-reset block
// Assumes: 125 MHz clock, 32-bit plain register port
// Notes: rail vectors are ordered core, graphics, ram, 1v8, 1v24, memory
package pgrr_pkg;
  localparam int RAIL_N = 6;
  localparam int CORE = 0;
  localparam int GFX = 1;
  localparam int RAM = 2;
  localparam int R1V8 = 3;
  localparam int R1V24 = 4;
  localparam int MEM = 5;
  localparam int VC_W = 7;
  localparam int MV_W = 11;
  localparam int MODE_W = 4;
  localparam int EVT_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_FMASK = 8'h04;
  localparam logic [ADDR_W-1:0] A_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] A_CORE_VC = 8'h0c;
  localparam logic [ADDR_W-1:0] A_GFX_VC = 8'h10;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] A_IRQ_ST = 8'h18;
  localparam logic [ADDR_W-1:0] A_IRQ_MSK = 8'h1c;

  // control register bits
  localparam int B_SOFT_SHUTDOWN_BIT = 0;
  localparam int B_AUX_ON = 1;

  // interrupt event bits
  localparam int E_RRG_FALL = 0;
  localparam int E_PWROK_FALL = 1;
  localparam int E_REG_RST = 2;
  localparam int E_FAULT = 3;
  localparam int E_VC_RST = 4;

  localparam logic [RAIL_N-1:0] FMASK_RST = 6'h00;
  localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
  localparam logic [EVT_W-1:0] IRQ_MSK_RST = 5'h00;
  localparam logic [VC_W-1:0] VC_OFF = 7'h00;
  localparam logic [VC_W-1:0] VC_SAT = 7'h76;
  localparam logic [MV_W-1:0] MV_OFF = 11'h000;
  localparam logic [MV_W-1:0] MV_BASE = 11'h1ea;
  localparam logic [MV_W-1:0] MV_STEP = 11'h00a;
endpackage

/* File: verilog/pgrr_sync.sv */
// Purpose: two-stage synchroniser for a vector of pin levels
// Assumes: inputs are quasi-static levels, not buses
// Notes: stage one feeds stage two only
`timescale 1ns/1ns
module pgrr_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= INIT;
      q_o <= INIT;
    end
    else if (ce_i)
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

/* File: verilog/pgrr_top.sv */
// Purpose: power-good trees and register-reset control of the pmic
// Assumes: pins asynchronous; dvs flags and register port on CLK_I
// Notes: software registers live here; analog loops are outside
`timescale 1ns/1ns
module pgrr_top
  import pgrr_pkg::*;
#(
  parameter logic [VC_W-1:0] CORE_VC_RST = 7'h38,
  parameter logic [VC_W-1:0] GFX_VC_RST = 7'h33,
  parameter logic AUX_ON_RST = 1'b0
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire logic SUPPLY_OK_I,
  input wire logic SUPPLY_LOW_I,
  input wire logic CHIP_EN_I,
  input wire logic THERMAL_TRIP_N_I,
  input wire logic SLEEP_S4_N_I,
  input wire logic SLEEP_S3_N_I,
  input wire logic SLEEP_S0IX_N_I,
  input wire logic CRIT_TEMP_I,
  input wire logic [RAIL_N-1:0] RAIL_GOOD_I,
  input wire logic [RAIL_N-1:0] RAIL_FAULT_I,
  input wire logic [RAIL_N-1:0] DVS_ACTIVE_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  output logic RESUME_RESET_GOOD_N_O,
  output logic PLATFORM_POWER_OK_O,
  output logic [RAIL_N-1:0] PWM_FORCE_O,
  output logic [MV_W-1:0] CORE_MV_O,
  output logic [MV_W-1:0] GFX_MV_O,
  output logic REG_RESET_O,
  output logic SHUTDOWN_O,
  output logic IRQ_O
);
  localparam int SYNC_W = 2 * RAIL_N + 8;
  // all-low start: no falling edge and no supply-low cause can follow reset
  localparam logic [SYNC_W-1:0] SYNC_INIT = '0;

  function automatic logic [MV_W-1:0] vc_to_mv(input logic [VC_W-1:0] vc);
    logic [VC_W-1:0] c;
    c = (vc >= VC_SAT) ? VC_SAT : vc;
    if (vc == VC_OFF)
      vc_to_mv = MV_OFF;
    else
      vc_to_mv = MV_W'(MV_BASE + MV_STEP * MV_W'(c));
  endfunction

  // edge decodes shared by the reset, vcode and hand-over logic
  function automatic logic fell(input logic was, input logic cur);
    fell = was & ~cur;
  endfunction

  function automatic logic rose(input logic was, input logic cur);
    rose = ~was & cur;
  endfunction

  logic [SYNC_W-1:0] pin_sync;
  logic [SYNC_W-1:0] pin_prev_reg;
  logic sup_ok;
  logic sup_low;
  logic en;
  logic trip_n;
  logic s4_n;
  logic s3_n;
  logic s0ix_n;
  logic crit;
  logic [RAIL_N-1:0] good;
  logic [RAIL_N-1:0] fault;
  logic en_prev;
  logic trip_prev;
  logic s3_prev;
  logic s0ix_prev;
  logic crit_prev;
  logic [RAIL_N-1:0] rail_ok;
  logic trip_ok;
  logic base_q;
  logic rrg_q;
  logic pwrok_q;
  logic unmasked_fault;
  logic soft_shutdown_bit_wr;
  logic reg_rst;
  logic vc_rst;
  logic rrg_fall;
  logic pwrok_fall;
  logic trip_armed_reg;
  logic core_moved_reg;
  logic aux_on_reg;
  logic [RAIL_N-1:0] fmask_reg;
  logic [MODE_W-1:0] mode_reg;
  logic [VC_W-1:0] core_vc_reg;
  logic [VC_W-1:0] gfx_vc_reg;
  logic [EVT_W-1:0] irq_st_reg;
  logic [EVT_W-1:0] irq_msk_reg;
  logic [EVT_W-1:0] evt;
  logic [DATA_W-1:0] rd_next;

  // every pin crosses two flops before any tree or edge decode reads it
  pgrr_sync #(
    .WIDTH(SYNC_W),
    .INIT(SYNC_INIT)
  ) u_sync (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .d_i({RAIL_FAULT_I, RAIL_GOOD_I, CRIT_TEMP_I, SLEEP_S0IX_N_I,
          SLEEP_S3_N_I, SLEEP_S4_N_I, THERMAL_TRIP_N_I, CHIP_EN_I,
          SUPPLY_LOW_I, SUPPLY_OK_I}),
    .q_o(pin_sync)
  );

  assign sup_ok = pin_sync[0];
  assign sup_low = pin_sync[1];
  assign en = pin_sync[2];
  assign trip_n = pin_sync[3];
  assign s4_n = pin_sync[4];
  assign s3_n = pin_sync[5];
  assign s0ix_n = pin_sync[6];
  assign crit = pin_sync[7];
  assign good = pin_sync[8 +: RAIL_N];
  assign fault = pin_sync[8+RAIL_N +: RAIL_N];
  assign en_prev = pin_prev_reg[2];
  assign trip_prev = pin_prev_reg[3];
  assign s3_prev = pin_prev_reg[5];
  assign s0ix_prev = pin_prev_reg[6];
  assign crit_prev = pin_prev_reg[7];

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      pin_prev_reg <= SYNC_INIT;
    else if (CE_I)
      pin_prev_reg <= pin_sync;
  end

  // a rail in a voltage transition counts as good
  assign rail_ok = good | DVS_ACTIVE_I;
  assign unmasked_fault = |(fault & ~fmask_reg);
  assign trip_ok = trip_n | ~trip_armed_reg;
  // any fault drops the trees even if masked from register reset
  assign base_q = sup_ok & en & trip_ok & ~(|fault);
  assign rrg_q = base_q & (rail_ok[CORE] | core_moved_reg)
               & rail_ok[R1V8] & rail_ok[R1V24];
  assign pwrok_q = rrg_q & s4_n & s3_n & rail_ok[MEM] & rail_ok[RAM]
                 & rail_ok[GFX] & (rail_ok[CORE] | ~core_moved_reg);

  assign soft_shutdown_bit_wr = WR_I & (ADDR_I == A_CTRL) & WDATA_I[B_SOFT_SHUTDOWN_BIT];
  assign reg_rst = sup_low
                 | (fell(en_prev, en) & ~aux_on_reg)
                 | (fell(trip_prev, trip_n) & RESUME_RESET_GOOD_N_O)
                 | unmasked_fault
                 | rose(crit_prev, crit)
                 | soft_shutdown_bit_wr;
  assign vc_rst = fell(s0ix_prev, s0ix_n) | fell(s3_prev, s3_n);
  assign rrg_fall = RESUME_RESET_GOOD_N_O & ~rrg_q;
  assign pwrok_fall = PLATFORM_POWER_OK_O & ~pwrok_q;

  // outputs registered: one cycle after qualifier loss, no filter
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      RESUME_RESET_GOOD_N_O <= 1'b0;
      PLATFORM_POWER_OK_O <= 1'b0;
    end
    else if (CE_I)
    begin
      RESUME_RESET_GOOD_N_O <= rrg_q;
      PLATFORM_POWER_OK_O <= pwrok_q;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      trip_armed_reg <= 1'b0;
    else if (CE_I && RESUME_RESET_GOOD_N_O)
      trip_armed_reg <= 1'b1;
  end

  // enable rise re-opens the first power-ok window
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      core_moved_reg <= 1'b0;
    else if (CE_I)
    begin
      if (rose(en_prev, en))
        core_moved_reg <= 1'b0;
      else if (PLATFORM_POWER_OK_O)
        core_moved_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      REG_RESET_O <= 1'b0;
      SHUTDOWN_O <= 1'b0;
    end
    else if (CE_I)
    begin
      REG_RESET_O <= reg_rst;
      SHUTDOWN_O <= soft_shutdown_bit_wr | rose(crit_prev, crit);
    end
  end

  // register reset beats a write in the same cycle
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I || (CE_I && reg_rst))
    begin
      aux_on_reg <= AUX_ON_RST;
      fmask_reg <= FMASK_RST;
      mode_reg <= MODE_RST;
      irq_msk_reg <= IRQ_MSK_RST;
    end
    else if (CE_I && WR_I)
    begin
      if (ADDR_I == A_CTRL)
        aux_on_reg <= WDATA_I[B_AUX_ON];
      else if (ADDR_I == A_FMASK)
        fmask_reg <= WDATA_I[RAIL_N-1:0];
      else if (ADDR_I == A_MODE)
        mode_reg <= WDATA_I[MODE_W-1:0];
      else if (ADDR_I == A_IRQ_MSK)
        irq_msk_reg <= WDATA_I[EVT_W-1:0];
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I || (CE_I && (reg_rst || vc_rst)))
    begin
      core_vc_reg <= CORE_VC_RST;
      gfx_vc_reg <= GFX_VC_RST;
    end
    else if (CE_I && WR_I)
    begin
      if (ADDR_I == A_CORE_VC)
        core_vc_reg <= WDATA_I[VC_W-1:0];
      else if (ADDR_I == A_GFX_VC)
        gfx_vc_reg <= WDATA_I[VC_W-1:0];
    end
  end

  // core and graphics bits tied low: no force path exists
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      PWM_FORCE_O <= '0;
      CORE_MV_O <= MV_OFF;
      GFX_MV_O <= MV_OFF;
    end
    else if (CE_I)
    begin
      PWM_FORCE_O <= {mode_reg, 2'b00};
      CORE_MV_O <= vc_to_mv(core_vc_reg);
      GFX_MV_O <= vc_to_mv(gfx_vc_reg);
    end
  end

  assign evt[E_RRG_FALL] = rrg_fall;
  assign evt[E_PWROK_FALL] = pwrok_fall;
  assign evt[E_REG_RST] = reg_rst;
  assign evt[E_FAULT] = |fault;
  assign evt[E_VC_RST] = vc_rst;

  // set wins over write-one-to-clear; status survives register reset
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      irq_st_reg <= '0;
    else if (CE_I)
    begin
      if (WR_I && ADDR_I == A_IRQ_ST)
        irq_st_reg <= (irq_st_reg & ~WDATA_I[EVT_W-1:0]) | evt;
      else
        irq_st_reg <= irq_st_reg | evt;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      IRQ_O <= 1'b0;
    else if (CE_I)
      IRQ_O <= |(irq_st_reg & irq_msk_reg);
  end

  always_comb
  begin
    rd_next = '0;
    if (ADDR_I == A_CTRL)
      rd_next[B_AUX_ON] = aux_on_reg;
    else if (ADDR_I == A_FMASK)
      rd_next[RAIL_N-1:0] = fmask_reg;
    else if (ADDR_I == A_MODE)
      rd_next[MODE_W-1:0] = mode_reg;
    else if (ADDR_I == A_CORE_VC)
      rd_next[VC_W-1:0] = core_vc_reg;
    else if (ADDR_I == A_GFX_VC)
      rd_next[VC_W-1:0] = gfx_vc_reg;
    else if (ADDR_I == A_STATUS)
      rd_next[3:0] = {core_moved_reg, trip_armed_reg,
                      PLATFORM_POWER_OK_O, RESUME_RESET_GOOD_N_O};
    else if (ADDR_I == A_IRQ_ST)
      rd_next[EVT_W-1:0] = irq_st_reg;
    else if (ADDR_I == A_IRQ_MSK)
      rd_next[EVT_W-1:0] = irq_msk_reg;
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      RDATA_O <= '0;
    else if (CE_I)
      RDATA_O <= RD_I ? rd_next : '0;
  end
endmodule
